// *** bench/four_pin_port_direction_pull_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module four_pin_port_direction_pull_ctrl_tb;
	import port_ctrl_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic spi_en = 0, lin_en = 0, serial_en = 0, lin_direct_drive_en = 0, rerr;
	logic [1:0] spi_dir = 2'h0, serial_dir = 2'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [3:0] pstrb = 4'hf, periph_out = 4'h6, timer_oc_en = 4'h0, ext_val = 4'h0, ext_en = 4'h0;
	logic [3:0] pin_in, pin_out, pin_oe_n, pull_on, pull_down;
	logic [19:0] tbl [6] = '{20'h0005a, 20'h00f00, 20'h100f8, 20'hb000b, 20'h0d0f1, 20'h0100d};
	// Expected pad data: claimed pins carry periph_out, the rest the latch value 5
	logic [3:0] pout [6] = '{4'h5, 4'h6, 4'h5, 4'h5, 4'h6, 4'h7};
	int fail_count = 0, n_tests = 0;
	always #5 pclk = ~pclk;
	four_pin_port_direction_pull_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .periph_out(periph_out), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pull_on(pull_on), .pull_down(pull_down), .spi_en(spi_en), .spi_dir(spi_dir), .lin_en(lin_en),
		.serial_en(serial_en), .serial_dir(serial_dir), .lin_direct_drive_en(lin_direct_drive_en),
		.timer_oc_en(timer_oc_en));
	port_pin_model pins_u (.pclk(pclk), .presetn(presetn), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pull_on(pull_on), .pull_down(pull_down), .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_in));
	// ------------------------------------------------------------
	// Bus and compare helpers
	// ------------------------------------------------------------
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd_chk
	task test_done;
		$display("tests=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	initial begin
		#100000;
		fail_count++;
		test_done();
	end
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 3; i++) rd_chk(OFS_PIN_DIRECTION + 12'(4 * i), 32'h0);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_PIN_DIRECTION + 12'(4 * i), 32'hffff_ffa5);
			rd_chk(OFS_PIN_DIRECTION + 12'(4 * i), 32'h5);
		end
		ext_val <= 4'ha;
		ext_en <= 4'hf;
		apb(1'b1, OFS_OUTPUT_LATCH, 32'h5);
		apb(1'b1, OFS_PULL_ENABLE, 32'h0);
		apb(1'b1, OFS_PIN_DIRECTION, 32'h3);
		repeat (8) @(posedge pclk);
		rd_chk(OFS_OUTPUT_LATCH, 32'h9);
		rd_chk(OFS_PIN_INPUT_VIEW, 32'h9);
		apb(1'b1, OFS_PIN_DIRECTION, 32'hf);
		repeat (8) @(posedge pclk);
		rd_chk(OFS_PIN_INPUT_VIEW, 32'h5);
		apb(1'b1, OFS_PIN_INPUT_VIEW, 32'ha);
		chk({31'h0, rerr}, 32'h1);
		rd_chk(OFS_PIN_INPUT_VIEW, 32'h5);
		rd_chk(12'h020, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		ext_en <= 4'h0;
		apb(1'b1, OFS_PIN_DIRECTION, 32'h0);
		apb(1'b1, OFS_PULL_ENABLE, 32'hf);
		repeat (8) @(posedge pclk);
		chk({28'h0, pull_on}, 32'hf);
		chk({28'h0, pull_down}, 32'h5);
		rd_chk(OFS_PIN_INPUT_VIEW, 32'ha);
		apb(1'b1, OFS_PIN_DIRECTION, 32'h3);
		repeat (2) @(posedge pclk);
		chk({28'h0, pull_on}, 32'hc);
		apb(1'b1, OFS_PULL_ENABLE, 32'h0);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, OFS_PIN_DIRECTION, {28'h0, tbl[i][7:4]});
			{spi_en, spi_dir, lin_en, serial_en, serial_dir, lin_direct_drive_en, timer_oc_en} <= tbl[i][19:8];
			repeat (3) @(posedge pclk);
			chk({28'h0, pin_oe_n}, {28'h0, tbl[i][3:0]});
			chk({28'h0, pin_out}, {28'h0, pout[i]});
			rd_chk(OFS_PIN_DIRECTION, {28'h0, tbl[i][7:4]});
			{spi_en, spi_dir, lin_en, serial_en, serial_dir, lin_direct_drive_en, timer_oc_en} <= 12'h000;
		end
		// Mid-run reset: registers and pads return to their reset state
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({28'h0, pin_oe_n}, 32'hf);
		chk({28'h0, pull_on}, 32'h0);
		presetn <= 1'b1;
		rd_chk(OFS_PULL_POLARITY, 32'h0);
		test_done();
	end
endmodule : four_pin_port_direction_pull_ctrl_tb
`default_nettype wire

// *** bench/port_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module port_ctrl_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pready,
	input wire logic [3:0] pin_oe_n,
	input wire logic [3:0] pull_on,
	input wire logic [3:0] pull_down,
	input wire logic spi_en,
	input wire logic [1:0] spi_dir,
	input wire logic lin_en,
	input wire logic serial_en,
	input wire logic [1:0] serial_dir,
	input wire logic lin_direct_drive_en,
	input wire logic [3:0] timer_oc_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// Direction overrides, one cycle after the claim
	// ------------------------------------------------------------
	sequence s_lin_only;
		lin_en && !spi_en;
	endsequence
	property p_spi; spi_en |=> pin_oe_n[3:2] == ~$past(spi_dir); endproperty
	a_spi: assert property (p_spi) else $error("spi direction wrong");
	property p_lin_tx; s_lin_only |=> pin_oe_n[3]; endproperty
	a_lin_tx: assert property (p_lin_tx) else $error("lin tx pin not input");
	property p_lin_rx; s_lin_only |=> !pin_oe_n[2]; endproperty
	a_lin_rx: assert property (p_lin_rx) else $error("lin rx pin not output");
	property p_ser; serial_en |=> pin_oe_n[1:0] == ~$past(serial_dir); endproperty
	a_ser: assert property (p_ser) else $error("serial direction wrong");
	property p_ldd; lin_direct_drive_en && !serial_en |=> !pin_oe_n[1]; endproperty
	a_ldd: assert property (p_ldd) else $error("direct drive pin not output");
	property p_timer; timer_oc_en[0] && !serial_en |=> !pin_oe_n[0]; endproperty
	a_timer: assert property (p_timer) else $error("timer pin not output");
	// ------------------------------------------------------------
	// Pull devices and APB ready
	// ------------------------------------------------------------
	property p_pull_out; (pull_on & ~pin_oe_n) == 4'h0; endproperty
	a_pull_out: assert property (p_pull_out) else $error("pull active on output");
	property p_pdown; (pull_down & ~pull_on) == 4'h0; endproperty
	a_pdown: assert property (p_pdown) else $error("pulldown without enable");
	property p_ready; pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
endmodule : port_ctrl_assertions
bind four_pin_port_direction_pull_ctrl port_ctrl_assertions chk_u (
	.pclk(pclk),
	.presetn(presetn),
	.pready(pready),
	.pin_oe_n(pin_oe_n),
	.pull_on(pull_on),
	.pull_down(pull_down),
	.spi_en(spi_en),
	.spi_dir(spi_dir),
	.lin_en(lin_en),
	.serial_en(serial_en),
	.serial_dir(serial_dir),
	.lin_direct_drive_en(lin_direct_drive_en),
	.timer_oc_en(timer_oc_en)
);
`default_nettype wire

// *** bench/port_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pad side: driver wins, then external source, then pull, else a toggling float
module port_pin_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe_n,
	input wire logic [3:0] pull_on,
	input wire logic [3:0] pull_down,
	input wire logic [3:0] ext_val,
	input wire logic [3:0] ext_en,
	output logic [3:0] pin_level
);
	logic [3:0] float_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) float_q <= 4'h5;
		else float_q <= ~float_q;
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
			else if (ext_en[i]) pin_level[i] = ext_val[i];
			else if (pull_on[i]) pin_level[i] = ~pull_down[i];
			else pin_level[i] = float_q[i];
		end
	end
endmodule : port_pin_model
`default_nettype wire

// *** rtl/dir_arbiter.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Per-pin direction arbitration
// ------------------------------------------------------------
module dir_arbiter (
	input wire logic [3:0] pin_direction,
	input wire logic spi_en,
	input wire logic [1:0] spi_dir,
	input wire logic lin_en,
	input wire logic serial_en,
	input wire logic [1:0] serial_dir,
	input wire logic lin_direct_drive_en,
	input wire logic [3:0] timer_oc_en,
	output logic [3:0] dir_eff,
	output port_ctrl_pkg::dir_src_t src [4]
);
	import port_ctrl_pkg::*;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			dir_eff[i] = pin_direction[i];
			src[i] = SRC_GPIO;
			if (timer_oc_en[i]) begin
				dir_eff[i] = 1'b1;
				src[i] = SRC_TIMER;
			end
		end
		// Upper pair: SPI outranks LIN, LIN outranks timer
		if (lin_en) begin
			dir_eff[PIN_LIN_TX] = 1'b0;
			dir_eff[PIN_LIN_RX] = 1'b1;
			src[PIN_LIN_TX] = SRC_LIN;
			src[PIN_LIN_RX] = SRC_LIN;
		end
		if (spi_en) begin
			dir_eff[PIN_SPI_HI] = spi_dir[1];
			dir_eff[PIN_SPI_LO] = spi_dir[0];
			src[PIN_SPI_HI] = SRC_SPI;
			src[PIN_SPI_LO] = SRC_SPI;
		end
		// Lower pair: direct drive uses pin 1 only
		if (lin_direct_drive_en) begin
			dir_eff[PIN_SER_HI] = 1'b1;
			src[PIN_SER_HI] = SRC_LIN;
		end
		if (serial_en) begin
			dir_eff[PIN_SER_HI] = serial_dir[1];
			dir_eff[PIN_SER_LO] = serial_dir[0];
			src[PIN_SER_HI] = SRC_SERIAL;
			src[PIN_SER_LO] = SRC_SERIAL;
		end
	end

endmodule : dir_arbiter
`default_nettype wire

// *** rtl/four_pin_port_direction_pull_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module four_pin_port_direction_pull_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [port_ctrl_pkg::ADDR_W-1:0] paddr,
	input wire logic [port_ctrl_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [port_ctrl_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	input wire logic [3:0] pin_in,
	input wire logic [3:0] periph_out,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe_n,
	output logic [3:0] pull_on,
	output logic [3:0] pull_down,
	// ------------------------------------------------------------
	// Peripheral direction claims
	// ------------------------------------------------------------
	input wire logic spi_en,
	input wire logic [1:0] spi_dir,
	input wire logic lin_en,
	input wire logic serial_en,
	input wire logic [1:0] serial_dir,
	input wire logic lin_direct_drive_en,
	input wire logic [3:0] timer_oc_en
);
	import port_ctrl_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [3:0] port_output_latch_q;
	logic [3:0] pin_direction_q;
	logic [3:0] pull_enable_q;
	logic [3:0] pull_polarity_q;
	logic [3:0] pin_sync;
	logic [3:0] dir_eff;
	dir_src_t src [4];
	logic [3:0] claimed;
	logic [DATA_W-1:0] prdata_d;
	logic wr_fire;
	logic rd_fire;
	logic mapped;

	function automatic logic [DATA_W-1:0] zext4(input logic [3:0] v);
		return {{(DATA_W-4){1'b0}}, v};
	endfunction : zext4

	// ------------------------------------------------------------
	// Input synchroniser and direction arbitration
	// ------------------------------------------------------------
	pin_input_sync #(
		.WIDTH(NUM_PINS)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_async(pin_in),
		.pin_sync(pin_sync)
	);

	dir_arbiter u_arb (
		.pin_direction(pin_direction_q),
		.spi_en(spi_en),
		.spi_dir(spi_dir),
		.lin_en(lin_en),
		.serial_en(serial_en),
		.serial_dir(serial_dir),
		.lin_direct_drive_en(lin_direct_drive_en),
		.timer_oc_en(timer_oc_en),
		.dir_eff(dir_eff),
		.src(src)
	);

	// ------------------------------------------------------------
	// APB decode: zero wait states, answer in the access cycle
	// ------------------------------------------------------------
	assign pready = 1'b1;
	assign wr_fire = psel && penable && pwrite;
	assign rd_fire = psel && !penable && !pwrite;

	always_comb begin
		mapped = 1'b1;
		unique case (paddr)
			OFS_OUTPUT_LATCH,
			OFS_PIN_INPUT_VIEW,
			OFS_PIN_DIRECTION,
			OFS_PULL_ENABLE,
			OFS_PULL_POLARITY,
			OFS_PERIPH_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Unmapped addresses and writes to read-only words error out
	assign pslverr = psel && penable && (!mapped ||
		(pwrite && (paddr == OFS_PIN_INPUT_VIEW || paddr == OFS_PERIPH_STATUS)));

	// ------------------------------------------------------------
	// Writable registers; only byte lane 0 carries data
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_output_latch_q <= RST_OUTPUT_LATCH;
		end else if (wr_fire && pstrb[0] && paddr == OFS_OUTPUT_LATCH) begin
			port_output_latch_q <= pwdata[3:0];
		end
	end

	// Only software writes reach this; peripherals never touch it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_direction_q <= RST_PIN_DIRECTION;
		end else if (wr_fire && pstrb[0] && paddr == OFS_PIN_DIRECTION) begin
			pin_direction_q <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pull_enable_q <= RST_PULL_ENABLE;
		end else if (wr_fire && pstrb[0] && paddr == OFS_PULL_ENABLE) begin
			pull_enable_q <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pull_polarity_q <= RST_PULL_POLARITY;
		end else if (wr_fire && pstrb[0] && paddr == OFS_PULL_POLARITY) begin
			pull_polarity_q <= pwdata[3:0];
		end
	end

	// ------------------------------------------------------------
	// Read path: data registered in setup, valid in access phase
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			claimed[i] = (src[i] != SRC_GPIO);
		end
	end

	always_comb begin
		prdata_d = '0;
		unique case (paddr)
			OFS_OUTPUT_LATCH: prdata_d = zext4((pin_direction_q & port_output_latch_q) |
				(~pin_direction_q & pin_sync));
			OFS_PIN_INPUT_VIEW: prdata_d = zext4(pin_sync);
			OFS_PIN_DIRECTION: prdata_d = zext4(pin_direction_q);
			OFS_PULL_ENABLE: prdata_d = zext4(pull_enable_q);
			OFS_PULL_POLARITY: prdata_d = zext4(pull_polarity_q);
			OFS_PERIPH_STATUS: prdata_d = {{(DATA_W-8){1'b0}}, claimed, dir_eff};
			default: prdata_d = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_fire) begin
			prdata <= prdata_d;
		end
	end

	// ------------------------------------------------------------
	// Pad control
	// ------------------------------------------------------------
	// Registered pads avoid glitches when overrides switch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_oe_n <= 4'hf;
			pin_out <= 4'h0;
		end else begin
			pin_oe_n <= ~dir_eff;
			for (int i = 0; i < 4; i++) begin
				pin_out[i] <= claimed[i] ? periph_out[i] : port_output_latch_q[i];
			end
		end
	end

	// Pull only on pins that really act as inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pull_on <= 4'h0;
			pull_down <= 4'h0;
		end else begin
			pull_on <= pull_enable_q & ~dir_eff;
			pull_down <= pull_enable_q & ~dir_eff & pull_polarity_q;
		end
	end

endmodule : four_pin_port_direction_pull_ctrl
`default_nettype wire

// *** rtl/pin_input_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Pin input synchroniser: three stages, change accepted when
// the second and third stages agree
// ------------------------------------------------------------
module pin_input_sync #(
	parameter int unsigned WIDTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] pin_sync
);
	import port_ctrl_pkg::*;

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	// First stage is read by the second stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			meta_q <= pin_async;
			s2_q <= meta_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					pin_sync[i] <= s3_q[i];
				end
			end
		end
	end

endmodule : pin_input_sync
`default_nettype wire

// *** rtl/port_ctrl_pkg.sv ***
`default_nettype none
package port_ctrl_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int unsigned NUM_PINS = 4;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// ------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_OUTPUT_LATCH = 12'h000;
	localparam logic [11:0] OFS_PIN_INPUT_VIEW = 12'h004;
	localparam logic [11:0] OFS_PIN_DIRECTION = 12'h008;
	localparam logic [11:0] OFS_PULL_ENABLE = 12'h00c;
	localparam logic [11:0] OFS_PULL_POLARITY = 12'h010;
	localparam logic [11:0] OFS_PERIPH_STATUS = 12'h014;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [3:0] RST_OUTPUT_LATCH = 4'h0;
	localparam logic [3:0] RST_PIN_DIRECTION = 4'h0;
	localparam logic [3:0] RST_PULL_ENABLE = 4'h0;
	localparam logic [3:0] RST_PULL_POLARITY = 4'h0;

	// ------------------------------------------------------------
	// Pin positions of the shared functions
	// ------------------------------------------------------------
	localparam int unsigned PIN_SPI_HI = 3;
	localparam int unsigned PIN_SPI_LO = 2;
	localparam int unsigned PIN_LIN_TX = 3;
	localparam int unsigned PIN_LIN_RX = 2;
	localparam int unsigned PIN_SER_HI = 1;
	localparam int unsigned PIN_SER_LO = 0;

	// Synchroniser depth on pin inputs
	localparam int unsigned SYNC_STAGES = 3;

	// Direction source that won a pin
	typedef enum logic [2:0] {
		SRC_GPIO,
		SRC_TIMER,
		SRC_LIN,
		SRC_SERIAL,
		SRC_SPI
	} dir_src_t;

endpackage : port_ctrl_pkg
`default_nettype wire
